// ===== hw/sfed_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
module sfed_spi_slave
	import sfed_pkg::*;
(
	input  wire logic clk_sys,          // System clock, 20 MHz.
	input  wire logic rst_n,            // Asynchronous reset, active low.
	input  wire logic cs_n,             // Chip select pin, active low.
	input  wire logic sclk,             // Serial clock pin from the master.
	input  wire logic mosi,             // Serial data in.
	output logic      miso,             // Serial data out.
	output logic      miso_oe,          // High while this device drives MISO.
	output logic      frame_error_flag  // Sticky frame error, status bit 9.
);
	logic cs_s1, cs_s2, cs_d;
	logic sclk_s1, sclk_s2, sclk_d;
	logic mosi_s1, mosi_s2;
	logic cs_fall, cs_rise, sclk_fall, sclk_rise, selected;

	logic [CNT_W-1:0]  bit_cnt_reg;
	logic [RX_W-1:0]   rx_reg;
	logic [CNT_W-1:0]  stray_cnt_reg;
	logic [2:0]        win_cnt_reg;
	logic              in_window;
	sfed_mode_t        mode_reg;
	logic              powered_reg;
	logic              act_pending_reg;
	logic              act_rw_reg;
	logic [5:0]        act_addr_reg;
	logic [7:0]        act_data_reg;
	logic [5:0]        rd_addr_reg;
	logic [RESP_W-1:0] resp_reg;
	logic              err_frame_reg;
	logic              err_crc_reg;
	logic              crc_en_reg;
	logic              miso_reg;
	logic              miso_oe_reg;

	logic              len_ok, sync_bad, stray_bad, frame_bad, count_stray, stray_fall;
	logic              f_rw;
	logic [5:0]        f_addr;
	logic [7:0]        f_data;
	logic              commit;
	logic              fifo_in_ready, fifo_out_valid, drain;
	logic [FIFO_W-1:0] fifo_out_data;
	logic              clr_frame, clr_crc;
	logic [15:0]       rd_word;
	logic [3:0]        rd_crc;

	function automatic logic [15:0] read_word(input logic [5:0] a, input logic fe,
			input logic ce, input logic cen);
		logic [5:0] base;
		base = {a[5:1], 1'b0};
		read_word = 16'h0000;
		if (base == ADDR_ERR_STATUS) begin
			read_word[15:12] = ERR_REG_ID;
			read_word[ERR_FRAME_BIT] = fe;
			read_word[ERR_CRC_BIT] = ce;
		end else if (base == ADDR_CTRL) begin
			read_word[CTRL_CRC_EN_BIT] = cen;
		end
	endfunction

	function automatic logic [3:0] crc4(input logic [15:0] d);
		logic [3:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = (c[3] ^ d[i]) ? ({c[2:0], 1'b0} ^ CRC_POLY) : {c[2:0], 1'b0};
		end
		crc4 = c;
	endfunction

	// Pins come from another clock; only the second and third stages feed logic.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{cs_s1, cs_s2, cs_d}       <= 3'h7;
			{sclk_s1, sclk_s2, sclk_d} <= 3'h7;
			{mosi_s1, mosi_s2}         <= 2'h0;
		end else begin
			cs_s1   <= cs_n;
			cs_s2   <= cs_s1;
			cs_d    <= cs_s2;
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_d  <= sclk_s2;
			mosi_s1 <= mosi;
			mosi_s2 <= mosi_s1;
		end
	end

	assign cs_fall   = cs_d & ~cs_s2;
	assign cs_rise   = ~cs_d & cs_s2;
	assign sclk_fall = sclk_d & ~sclk_s2;
	assign sclk_rise = ~sclk_d & sclk_s2;
	assign selected  = ~cs_s2;
	assign in_window = (win_cnt_reg != 3'h0);

	// Frame length comes from falling edges while selected.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_reg <= '0;
			rx_reg      <= '0;
		end else if (cs_fall) begin
			bit_cnt_reg <= '0;
			rx_reg      <= '0;
		end else if (selected) begin
			if (sclk_fall && bit_cnt_reg != CNT_MAX) begin
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
			end
			if (sclk_rise) begin
				rx_reg <= {rx_reg[RX_W-2:0], mosi_s2};
			end
		end
	end

	// Field positions depend on the frame length; the 21-bit frame ends with five unused bits.
	always_comb begin
		len_ok   = 1'b1;
		sync_bad = 1'b0;
		f_rw     = 1'b0;
		f_addr   = '0;
		f_data   = '0;
		unique case (bit_cnt_reg)
			LEN_16: {sync_bad, f_rw, f_addr, f_data} = rx_reg[15:0];
			LEN_20: {sync_bad, f_rw, f_addr, f_data} = rx_reg[19:4];
			LEN_21: {sync_bad, f_rw, f_addr, f_data} = rx_reg[20:5];
			default: len_ok = 1'b0;
		endcase
	end

	assign stray_bad = (stray_cnt_reg != '0);
	assign frame_bad = ~len_ok | sync_bad | stray_bad;
	assign stray_fall = sclk_fall & ~selected;

	// Which deselected edges count depends on the packet size last in use.
	always_comb begin
		count_stray = 1'b0;
		unique case (mode_reg)
			SFED_MODE16: count_stray = 1'b1;
			SFED_MODE20: count_stray = in_window | act_rw_reg;
			SFED_MODE21: count_stray = 1'b0;
		endcase
		if (!powered_reg) begin
			count_stray = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stray_cnt_reg <= '0;
		end else if (cs_rise) begin
			stray_cnt_reg <= '0;
		end else if (stray_fall && count_stray && stray_cnt_reg != CNT_MAX) begin
			stray_cnt_reg <= stray_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			win_cnt_reg <= 3'h0;
		end else if (cs_rise) begin
			win_cnt_reg <= WIN_LOAD;
		end else if (in_window) begin
			win_cnt_reg <= win_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg    <= SFED_MODE16;
			powered_reg <= 1'b0;
		end else if (cs_rise) begin
			powered_reg <= 1'b1;
			if (bit_cnt_reg == LEN_20) begin
				mode_reg <= SFED_MODE20;
			end else if (bit_cnt_reg == LEN_21) begin
				mode_reg <= SFED_MODE21;
			end else if (bit_cnt_reg == LEN_16) begin
				mode_reg <= SFED_MODE16;
			end
		end
	end

	// A well formed frame is held until the discard window closes.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			act_pending_reg <= 1'b0;
			act_rw_reg      <= 1'b0;
			act_addr_reg    <= '0;
			act_data_reg    <= '0;
		end else if (cs_rise) begin
			act_pending_reg <= len_ok & ~sync_bad;
			act_rw_reg      <= f_rw;
			act_addr_reg    <= f_addr;
			act_data_reg    <= f_data;
		end else if (stray_fall && in_window) begin
			act_pending_reg <= 1'b0;
		end else if (commit) begin
			act_pending_reg <= 1'b0;
		end
	end

	assign commit = act_pending_reg && (win_cnt_reg == 3'h1) && !stray_fall;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_addr_reg <= '0;
		end else if (commit && !act_rw_reg) begin
			rd_addr_reg <= act_addr_reg;
		end
	end

	assign rd_word = read_word(commit && !act_rw_reg ? act_addr_reg : rd_addr_reg,
		err_frame_reg, err_crc_reg, crc_en_reg);
	assign rd_crc  = crc4(rd_word);

	// The response is staged ahead of the next frame; a discard restages the last valid read.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			resp_reg <= '0;
		end else if (commit) begin
			resp_reg <= {rd_word, rd_crc, rd_crc[3]};
		end else if (stray_fall && in_window) begin
			resp_reg <= {rd_word, rd_crc, rd_crc[3]};
		end else if (selected && sclk_fall) begin
			resp_reg <= {resp_reg[RESP_W-2:0], 1'b0};
		end else if (stray_fall && !in_window && mode_reg == SFED_MODE16) begin
			resp_reg <= {resp_reg[RESP_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			miso_reg    <= 1'b0;
			miso_oe_reg <= 1'b0;
		end else begin
			miso_oe_reg <= selected;
			if (cs_fall) begin
				miso_reg <= resp_reg[RESP_W-1];
			end else if (selected && sclk_fall) begin
				miso_reg <= resp_reg[RESP_W-2];
			end
		end
	end

	// Writes wait here and land in the registers only between frames.
	sfed_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_data   ({act_addr_reg, act_data_reg}),
		.in_valid  (commit & act_rw_reg),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (~selected)
	);

	assign drain     = fifo_out_valid & ~selected;
	assign clr_frame = drain && fifo_out_data[13:8] == ADDR_ERR_STATUS
		&& fifo_out_data[CLR_FRAME_BIT];
	assign clr_crc   = drain && fifo_out_data[13:8] == ADDR_ERR_STATUS
		&& fifo_out_data[CLR_CRC_BIT];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crc_en_reg <= 1'b0;
		end else if (drain && fifo_out_data[13:8] == ADDR_CTRL_LO) begin
			crc_en_reg <= fifo_out_data[CTRL_CRC_EN_BIT];
		end
	end

	// A new error wins over a clear in the same cycle; a full queue also counts as bad.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			err_frame_reg <= 1'b0;
			err_crc_reg   <= 1'b0;
		end else begin
			if ((cs_rise && frame_bad) || (commit && act_rw_reg && !fifo_in_ready)) begin
				err_frame_reg <= 1'b1;
			end else if (clr_frame) begin
				err_frame_reg <= 1'b0;
			end
			if (cs_rise && stray_bad && !powered_reg && crc_en_reg) begin
				err_crc_reg <= 1'b1;
			end else if (clr_crc) begin
				err_crc_reg <= 1'b0;
			end
		end
	end

	assign miso             = miso_reg;
	assign miso_oe          = miso_oe_reg;
	assign frame_error_flag = err_frame_reg;

	frame_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cs_rise && !len_ok |=> err_frame_reg)
		else $error("bad edge count did not set frame error");

	sync_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cs_rise && sync_bad |=> frame_error_flag)
		else $error("leading one did not set frame error");

	stray16_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_reg == SFED_MODE16 && stray_fall && !cs_rise |=> stray_cnt_reg != '0)
		else $error("stray edge in 16-bit mode not counted");

	ignore21_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		powered_reg && mode_reg == SFED_MODE21 && !cs_rise |=> $stable(stray_cnt_reg)
		|| cs_rise)
		else $error("21-bit mode counted a deselected edge");

	sticky_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		err_frame_reg && !clr_frame |=> err_frame_reg)
		else $error("frame error dropped without a clear");

	discard_win_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stray_fall && in_window && !cs_rise |=> !act_pending_reg && $stable(rd_addr_reg))
		else $error("early stray edge did not discard the frame");

	dup_crc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		commit |=> resp_reg[0] == resp_reg[4] && resp_reg[4:1] == crc4(resp_reg[20:5]))
		else $error("response tail does not repeat the CRC MSB");

	poweron_crc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cs_rise && !powered_reg && stray_bad && crc_en_reg |=> err_crc_reg && err_frame_reg)
		else $error("power-on bad packet did not set CRC error");

	keep20_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_reg == SFED_MODE20 && stray_fall && !in_window && !commit |=> $stable(resp_reg))
		else $error("20-bit stray edge corrupted the staged response");
endmodule
`default_nettype wire

// ===== hw/sfed_pkg.sv
package sfed_pkg;
	localparam int          CNT_W           = 5;
	localparam logic [4:0]  LEN_16          = 5'h10;
	localparam logic [4:0]  LEN_20          = 5'h14;
	localparam logic [4:0]  LEN_21          = 5'h15;
	localparam logic [4:0]  CNT_MAX         = 5'h1f;
	localparam int          RX_W            = 21;
	localparam int          RESP_W          = 21;
	localparam logic [5:0]  ADDR_ERR_STATUS = 6'h24;
	localparam logic [5:0]  ADDR_CTRL       = 6'h02;
	localparam logic [5:0]  ADDR_CTRL_LO    = 6'h03;
	localparam int          ERR_FRAME_BIT   = 9;
	localparam int          ERR_CRC_BIT     = 8;
	localparam int          CLR_FRAME_BIT   = 1;
	localparam int          CLR_CRC_BIT     = 0;
	localparam int          CTRL_CRC_EN_BIT = 0;
	// Register identifier nibble; the value is arbitrary.
	localparam logic [3:0]  ERR_REG_ID      = 4'h5;
	localparam logic [3:0]  CRC_POLY        = 4'h3;
	localparam logic [3:0]  CRC_INIT        = 4'hf;
	localparam int          CLK_PERIOD_NS   = 50;
	localparam int          T_DISCARD_NS    = 70;
	localparam int          T_DISCARD_RAW   = T_DISCARD_NS / CLK_PERIOD_NS;
	localparam int          T_DISCARD_CYC   = (T_DISCARD_RAW < 1) ? 1 : T_DISCARD_RAW;
	localparam logic [2:0]  WIN_LOAD        = 3'(T_DISCARD_CYC);
	localparam int          FIFO_W          = 14;
	localparam int          FIFO_DEPTH      = 8;

	typedef enum logic [2:0] {
		SFED_MODE16 = 3'b001,
		SFED_MODE20 = 3'b010,
		SFED_MODE21 = 3'b100
	} sfed_mode_t;
endpackage

// ===== hw/sfed_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sfed_fifo #(
	parameter int W     = 14,
	parameter int DEPTH = 8
) (
	input  wire logic         clk_sys,   // System clock.
	input  wire logic         rst_n,     // Asynchronous reset, active low.
	input  wire logic [W-1:0] in_data,   // Word to store.
	input  wire logic         in_valid,  // Word offered.
	output logic              in_ready,  // Room for a word.
	output logic      [W-1:0] out_data,  // Oldest word.
	output logic              out_valid, // A word is held.
	input  wire logic         out_ready  // Consumer takes the word.
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic          push;
	logic          pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ===== test/sfed_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module sfed_spi_master (
	input  wire logic clk_sys, // Bench clock, paces the link.
	input  wire logic miso,    // Data from the device.
	input  wire logic miso_oe, // High while the device drives data.
	output logic      cs_n,    // Select, active low.
	output logic      sclk,    // Link clock, idles high.
	output logic      mosi     // Data to the device.
);
	logic miso_last;
	logic miso_line;

	// A released data line shows the inverse of its last level, so a stale bit cannot pass.
	always @(posedge clk_sys) begin
		if (miso_oe === 1'b1)
			miso_last <= miso;
	end
	assign miso_line = (miso_oe === 1'b1) ? miso : ~miso_last;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		mosi = 1'b0;
		miso_last = 1'b0;
	end

	// Half of the 400 ns link period.
	task automatic half();
		repeat (4) @(negedge clk_sys);
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			sclk = 1'b0;
			half();
			sclk = 1'b1;
			half();
		end
	endtask

	task automatic xfer(input int n, input logic [20:0] tx, input int dly, input int ns,
		output logic [20:0] rx);
		rx = '0;
		@(negedge clk_sys);
		cs_n = 1'b0;
		half();
		// The device shows its first bit at select and moves on only after each synced
		// falling edge, so the reply is taken at the falling edge itself.
		for (int i = n - 1; i >= 0; i--) begin
			rx[i] = miso_line;
			sclk = 1'b0;
			mosi = tx[i];
			half();
			sclk = 1'b1;
			half();
		end
		cs_n = 1'b1;
		mosi = ~mosi;
		repeat (dly) @(negedge clk_sys);
		pulses(ns);
		repeat (8) @(negedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ===== test/spi_frame_error_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_frame_error_detect_tb;
	import sfed_pkg::*;
	logic              clk_sys, rst_n, cs_n, sclk, mosi, miso, miso_oe, flag;
	logic [20:0]       rx, tx;
	logic [7:0]        rnd;
	logic [5:0]        ua;
	logic [15:0]       exp_q[$];
	int                n_fail = 0, checks = 0, cyc = 0, seed, k;

	initial clk_sys = 1'b0;
	always #25 clk_sys = ~clk_sys;

	sfed_spi_slave u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
		.mosi(mosi), .miso(miso), .miso_oe(miso_oe), .frame_error_flag(flag));
	sfed_spi_master u_m (.clk_sys(clk_sys), .miso(miso), .miso_oe(miso_oe), .cs_n(cs_n),
		.sclk(sclk), .mosi(mosi));

	function automatic logic [20:0] pk(int n, logic rw, logic [5:0] a, logic [7:0] d);
		logic [15:0] b;
		b = {1'b0, rw, a, d};
		if (n == 21)
			return {b, 5'h00};
		if (n == 20)
			return {1'b0, b, 4'h0};
		return {5'h00, b};
	endfunction

	task automatic chk(input string what, input logic [20:0] e, input logic [20:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, e, g);
		end
	endtask

	task automatic go(int n, logic rw, logic [5:0] a, logic [7:0] d, int dly = 0, int ns = 0);
		u_m.xfer(n, pk(n, rw, a, d), dly, ns, rx);
	endtask

	task automatic stop_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		seed = 78;
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		u_m.pulses(2);
		go(16, 0, ADDR_ERR_STATUS, 0);
		chk("pwr_on_flag", 1, flag);
		go(16, 1, ADDR_ERR_STATUS, 8'h03);
		chk("pwr_on_clear", 0, flag);
		// Every write passes the queue; the model expects it back on the second read.
		for (k = 0; k < 3; k++) begin
			rnd = 8'($random(seed));
			exp_q.push_back({15'h0000, rnd[0]});
			go(16, 1, ADDR_CTRL_LO, rnd);
			go(16, 0, ADDR_CTRL, 0);
			go(16, 0, ADDR_CTRL, 0);
			chk("queue_data", exp_q.pop_front(), rx[15:0]);
		end
		chk("queue_flag", 0, flag);
		chk("miso_release", 0, miso_oe);
		rnd = 8'($random(seed));
		ua = 6'h04 + 6'($random(seed) & 15);
		go(16, 1, ADDR_CTRL_LO, rnd);
		go(16, 0, ADDR_CTRL, 0);
		go(16, 0, ua, 0);
		chk("ctrl_word", {15'h0000, rnd[0]}, rx[15:0]);
		go(16, 0, ADDR_ERR_STATUS, 0);
		chk("unmapped", 0, rx[15:0]);
		for (k = 0; k < 3; k++) begin
			tx = pk(16, 0, ADDR_ERR_STATUS, 0);
			case (k)
				0: u_m.xfer(15, tx >> 1, 0, 0, rx);
				1: u_m.xfer(17, tx << 1, 0, 0, rx);
				default: u_m.xfer(16, tx | 21'h08000, 0, 0, rx);
			endcase
			chk("bad_frame", 1, flag);
			go(16, 0, ADDR_ERR_STATUS, 0);
			chk("flag_held", 1, flag);
			go(16, 1, ADDR_ERR_STATUS, 8'h03);
			chk("status_word", 16'h5200, rx[15:0]);
			chk("cleared", 0, flag);
		end
		go(16, 0, ADDR_ERR_STATUS, 0, 2, 1);
		go(16, 0, ADDR_ERR_STATUS, 0);
		chk("stray16", 1, flag);
		go(16, 1, ADDR_ERR_STATUS, 8'h03);
		go(16, 0, ADDR_CTRL, 0);
		go(16, 0, ADDR_ERR_STATUS, 0, 1, 1);
		go(16, 1, ADDR_ERR_STATUS, 8'h03);
		chk("discard", {15'h0000, rnd[0]}, rx[15:0]);
		go(16, 1, ADDR_ERR_STATUS, 8'h03);
		go(16, 1, ADDR_CTRL_LO, 8'h00, 2, 1);
		go(16, 0, ADDR_CTRL, 0);
		chk("late_write", 1, flag);
		go(16, 1, ADDR_ERR_STATUS, 8'h03);
		go(16, 0, ADDR_CTRL, 0);
		go(16, 0, ADDR_ERR_STATUS, 0);
		chk("write_kept", 0, rx[15:0]);
		go(20, 0, ADDR_CTRL, 0);
		go(20, 0, ADDR_ERR_STATUS, 0, 2, 1);
		go(20, 0, ADDR_CTRL, 0);
		chk("resp20", 16'h5000, rx[19:4]);
		chk("flag20", 0, flag);
		go(21, 0, ADDR_ERR_STATUS, 0);
		go(21, 0, ADDR_ERR_STATUS, 0, 1, 2);
		go(21, 0, ADDR_CTRL, 0);
		chk("resp21", 16'h5000, rx[20:5]);
		chk("crc_repeat", rx[4], rx[0]);
		chk("flag21", 0, flag);
		stop_test();
	end
endmodule
`default_nettype wire
